// ### cef_flags.sv
`timescale 1ns/1ps
`include "cef_regs.svh"
module cef_flags
  import cef_pkg::*;
(
  input  wire logic           clock_in,
  input  wire logic           rst_n_in,
  input  wire logic           curr_reg_in,
  input  wire logic           volt_reg_in,
  input  wire logic           wdog_in,
  input  wire logic           weak_adapter_in,
  input  wire logic           power_good_state_in,
  input  wire logic           second_input_in,
  input  wire logic           first_input_in,
  input  wire logic           bus_present_in,
  input  wire cef_chg_state_t charge_state_in,
  input  wire logic           optimizer_event_in,
  input  wire cef_bus_state_t bus_state_in,
  input  wire logic           thermal_reg_in,
  input  wire logic           battery_present_in,
  input  wire logic           detection_state_in,
  input  wire logic           rd_en_in,
  input  wire logic [7:0]     rd_addr_in,
  output logic                rd_valid_out,
  output cef_byte_t           rd_data_out,
  output cef_byte_t           flags_a_out,
  output cef_byte_t           flags_b_out
);

  // ----------------------------------------
  // Previous input samples
  // ----------------------------------------
  logic           curr_d_r;
  logic           volt_d_r;
  logic           wdog_d_r;
  logic           weak_d_r;
  logic           pg_d_r;
  logic           in2_d_r;
  logic           in1_d_r;
  logic           bus_d_r;
  cef_chg_state_t chg_d_r;
  cef_bus_state_t vbus_d_r;
  logic           treg_d_r;
  logic           bat_d_r;
  logic           det_d_r;
  logic           primed_r;
  cef_byte_t      flags_a_r;
  cef_byte_t      flags_b_r;
  cef_byte_t      ev_a;
  cef_byte_t      ev_b;
  cef_byte_t      flags_a_nxt;
  cef_byte_t      flags_b_nxt;
  cef_byte_t      rd_sel;
  wire            rd_a = rd_en_in && (rd_addr_in == `CEF_OFS_FLAGS_A);
  wire            rd_b = rd_en_in && (rd_addr_in == `CEF_OFS_FLAGS_B);

  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  always_comb
  begin
    ev_a = 8'h00;
    ev_b = 8'h00;
    if (primed_r)
    begin
      ev_a[`CEF_A_CURR_BIT]  = curr_reg_in & ~curr_d_r;
      ev_a[`CEF_A_VOLT_BIT]  = volt_reg_in & ~volt_d_r;
      ev_a[`CEF_A_WDOG_BIT]  = wdog_in & ~wdog_d_r;
      ev_a[`CEF_A_WEAK_BIT]  = weak_adapter_in & ~weak_d_r;
      ev_a[`CEF_A_PGOOD_BIT] = power_good_state_in ^ pg_d_r;
      ev_a[`CEF_A_IN2_BIT]   = second_input_in ^ in2_d_r;
      ev_a[`CEF_A_IN1_BIT]   = first_input_in ^ in1_d_r;
      ev_a[`CEF_A_BUS_BIT]   = bus_present_in ^ bus_d_r;
      ev_b[`CEF_B_CHG_BIT]   = (charge_state_in != chg_d_r);
      ev_b[`CEF_B_ICO_BIT]   = optimizer_event_in;
      ev_b[`CEF_B_VBUS_BIT]  = (bus_state_in != vbus_d_r);
      ev_b[`CEF_B_TREG_BIT]  = thermal_reg_in & ~treg_d_r;
      ev_b[`CEF_B_BAT_BIT]   = battery_present_in ^ bat_d_r;
      ev_b[`CEF_B_DET_BIT]   = detection_state_in ^ det_d_r;
    end
  end

  // Set wins over read clear
  assign flags_a_nxt = (rd_a ? 8'h00 : flags_a_r) | ev_a;
  assign flags_b_nxt = ((rd_b ? 8'h00 : flags_b_r) | ev_b) & `CEF_B_RSVD_MASK;
  assign rd_sel      = rd_a ? flags_a_r : (rd_b ? flags_b_r : 8'h00);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      curr_d_r <= 1'h0;
    end
    else
    begin
      curr_d_r <= curr_reg_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      volt_d_r <= 1'h0;
    end
    else
    begin
      volt_d_r <= volt_reg_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      wdog_d_r <= 1'h0;
    end
    else
    begin
      wdog_d_r <= wdog_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      weak_d_r <= 1'h0;
    end
    else
    begin
      weak_d_r <= weak_adapter_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      pg_d_r <= 1'h0;
    end
    else
    begin
      pg_d_r <= power_good_state_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      in2_d_r <= 1'h0;
    end
    else
    begin
      in2_d_r <= second_input_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      in1_d_r <= 1'h0;
    end
    else
    begin
      in1_d_r <= first_input_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      bus_d_r <= 1'h0;
    end
    else
    begin
      bus_d_r <= bus_present_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      chg_d_r <= 3'h0;
    end
    else
    begin
      chg_d_r <= charge_state_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      vbus_d_r <= 3'h0;
    end
    else
    begin
      vbus_d_r <= bus_state_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      treg_d_r <= 1'h0;
    end
    else
    begin
      treg_d_r <= thermal_reg_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      bat_d_r <= 1'h0;
    end
    else
    begin
      bat_d_r <= battery_present_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      det_d_r <= 1'h0;
    end
    else
    begin
      det_d_r <= detection_state_in;
    end
  end

  // No events until every sample holds a real value
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      primed_r <= 1'h0;
    end
    else
    begin
      primed_r <= 1'h1;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      flags_a_r <= `CEF_RST_FLAGS;
    end
    else
    begin
      flags_a_r <= flags_a_nxt;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      flags_b_r <= `CEF_RST_FLAGS;
    end
    else
    begin
      flags_b_r <= flags_b_nxt;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      rd_valid_out <= 1'h0;
    end
    else
    begin
      rd_valid_out <= rd_en_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      rd_data_out <= 8'h00;
    end
    else
    begin
      rd_data_out <= rd_sel;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      flags_a_out <= `CEF_RST_FLAGS;
    end
    else
    begin
      flags_a_out <= flags_a_nxt;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      flags_b_out <= `CEF_RST_FLAGS;
    end
    else
    begin
      flags_b_out <= flags_b_nxt;
    end
  end

endmodule : cef_flags

// ### cef_flags_asserts.sv
`timescale 1ns/1ps
`include "cef_regs.svh"
module cef_flags_asserts
  import cef_pkg::*;
(
  input wire logic           clock_in,
  input wire logic           rst_n_in,
  input wire logic           curr_reg_in,
  input wire logic           power_good_state_in,
  input wire logic           thermal_reg_in,
  input wire logic           rd_en_in,
  input wire logic           rd_valid_out,
  input wire cef_chg_state_t charge_state_in,
  input wire logic [7:0]     rd_addr_in,
  input wire cef_byte_t      rd_data_out,
  input wire cef_byte_t      flags_a_out,
  input wire cef_byte_t      flags_b_out
);
  wire ra = rd_en_in && rd_addr_in == `CEF_OFS_FLAGS_A;
  wire rb = rd_en_in && rd_addr_in == `CEF_OFS_FLAGS_B;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  AST_RDA: assert property (ra |=> rd_valid_out && rd_data_out == $past(flags_a_out)) else $error("rd a");
  AST_RDB: assert property (rb |=> rd_data_out == $past(flags_b_out)) else $error("rd b");
  AST_UNM: assert property (rd_en_in && !ra && !rb |=> rd_data_out == 8'h00) else $error("unmapped");
  AST_RSV: assert property ((flags_b_out & 8'h28) == 8'h00) else $error("reserved");
  AST_CUR: assert property ($past(rst_n_in) && $rose(curr_reg_in) |=> flags_a_out[7]) else $error("curr");
  AST_PGD: assert property ($past(rst_n_in) && $changed(power_good_state_in) |=> flags_a_out[3]) else $error("pg");
  AST_CHG: assert property ($past(rst_n_in) && $changed(charge_state_in) |=> flags_b_out[7]) else $error("chg");
  AST_TRG: assert property ($past(rst_n_in) && $rose(thermal_reg_in) |=> flags_b_out[2]) else $error("treg");
  AST_HLD: assert property (flags_a_out[3] && !ra |=> flags_a_out[3]) else $error("hold");
endmodule : cef_flags_asserts
bind cef_flags cef_flags_asserts u_chk (
  .clock_in(clock_in),
  .rst_n_in(rst_n_in),
  .curr_reg_in(curr_reg_in),
  .power_good_state_in(power_good_state_in),
  .thermal_reg_in(thermal_reg_in),
  .rd_en_in(rd_en_in),
  .rd_valid_out(rd_valid_out),
  .charge_state_in(charge_state_in),
  .rd_addr_in(rd_addr_in),
  .rd_data_out(rd_data_out),
  .flags_a_out(flags_a_out),
  .flags_b_out(flags_b_out)
);

// ### cef_flags_tb.sv
`timescale 1ns/1ps
`include "cef_regs.svh"
module cef_flags_tb;
  import cef_pkg::*;
  logic        clock_in = 1'b0, rst_n_in = 1'b0, first = 1'b1, quiet = 1'b0, rd_en, rd_valid;
  logic [7:0]  rd_addr, ae = 8'h00, be = 8'h00, re;
  logic [17:0] v = 18'h0, p;
  logic [31:0] rs = 32'h19b2;
  cef_byte_t   rd_data, fa, fb, d;
  int          error_cnt = 0, samples_checked = 0;
  always #5 clock_in = ~clock_in;
  cef_flags dut (.clock_in, .rst_n_in, .curr_reg_in(v[17]), .volt_reg_in(v[16]), .wdog_in(v[15]),
    .weak_adapter_in(v[14]), .power_good_state_in(v[13]), .second_input_in(v[12]), .first_input_in(v[11]),
    .bus_present_in(v[10]), .charge_state_in(v[9:7]), .optimizer_event_in(v[6]), .bus_state_in(v[5:3]),
    .thermal_reg_in(v[2]), .battery_present_in(v[1]), .detection_state_in(v[0]), .rd_en_in(rd_en),
    .rd_addr_in(rd_addr), .rd_valid_out(rd_valid), .rd_data_out(rd_data), .flags_a_out(fa), .flags_b_out(fb));
  cef_host_model host (.clock_in, .rd_en_out(rd_en), .rd_addr_out(rd_addr), .rd_valid_in(rd_valid), .rd_data_in(rd_data));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  function automatic cef_byte_t exp_ev_a(input logic [17:0] n, o);
    return {n[17:14] & ~o[17:14], n[13:10] ^ o[13:10]};
  endfunction : exp_ev_a
  function automatic cef_byte_t exp_ev_b(input logic [17:0] n, o);
    return {|(n[9:7] ^ o[9:7]), n[6], 1'b0, |(n[5:3] ^ o[5:3]), 1'b0, n[2] & ~o[2], n[1:0] ^ o[1:0]};
  endfunction : exp_ev_b
  task automatic chk(input cef_byte_t s, e);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  always @(posedge clock_in)
  begin
    re = rd_addr == `CEF_OFS_FLAGS_A ? ae : rd_addr == `CEF_OFS_FLAGS_B ? be : 8'h00;
    if (rd_en && rd_addr == `CEF_OFS_FLAGS_A) ae = 8'h00;
    if (rd_en && rd_addr == `CEF_OFS_FLAGS_B) be = 8'h00;
    if (!first) ae |= exp_ev_a(v, p);
    if (!first) be |= exp_ev_b(v, p);
    if (!rst_n_in) {ae, be} = 16'h0;
    first = !rst_n_in;
    p = v;
  end
  always @(negedge clock_in)
  begin
    rs = xs(rs);
    if (rst_n_in) chk(fa, ae);
    if (rst_n_in) chk(fb, be);
    if (rst_n_in && !quiet && rs[2:0] == 3'h0) v = rs[30:13];
  end
  initial
  begin
    repeat (4) @(negedge clock_in);
    rst_n_in = 1'b1;
    repeat (600)
    begin
      host.rd(8'h21 + rs[12:11], d);
      chk(d, re);
    end
    $display("random reads done");
    quiet = 1'b1;
    rst_n_in = 1'b0;
    repeat (3) @(negedge clock_in);
    chk(fa, `CEF_RST_FLAGS);
    chk(fb, `CEF_RST_FLAGS);
    rst_n_in = 1'b1;
    repeat (2) @(negedge clock_in);
    fork
      host.rd(`CEF_OFS_FLAGS_A, d);
      begin
        @(negedge clock_in);
        v = ~v;
      end
    join
    chk(d, re);
    chk(fa, ae);
    host.rd(`CEF_OFS_FLAGS_B, d);
    chk(d, re);
    $display("reset and read-versus-event corner done");
    give_verdict();
  end
endmodule : cef_flags_tb

// ### cef_host_model.sv
`timescale 1ns/1ps
module cef_host_model
  import cef_pkg::*;
(
  input  wire logic      clock_in,
  output logic           rd_en_out = 1'b0,
  output logic [7:0]     rd_addr_out = 8'h00,
  input  wire logic      rd_valid_in,
  input  wire cef_byte_t rd_data_in
);
  task automatic rd(input logic [7:0] a, output cef_byte_t d);
    @(negedge clock_in);
    rd_en_out = 1'b1;
    rd_addr_out = a;
    @(negedge clock_in);
    rd_en_out = 1'b0;
    rd_addr_out = ~a;
    d = rd_valid_in ? rd_data_in : 8'hxx;
  endtask : rd
endmodule : cef_host_model

// ### cef_pkg.sv
package cef_pkg;
  typedef logic [7:0] cef_byte_t;
  typedef logic [2:0] cef_chg_state_t;
  typedef logic [2:0] cef_bus_state_t;
endpackage : cef_pkg

// ### cef_regs.svh
`ifndef CEF_REGS_SVH
`define CEF_REGS_SVH
`define CEF_OFS_FLAGS_A   8'h22
`define CEF_OFS_FLAGS_B   8'h23
`define CEF_RST_FLAGS     8'h00
`define CEF_A_CURR_BIT    7
`define CEF_A_VOLT_BIT    6
`define CEF_A_WDOG_BIT    5
`define CEF_A_WEAK_BIT    4
`define CEF_A_PGOOD_BIT   3
`define CEF_A_IN2_BIT     2
`define CEF_A_IN1_BIT     1
`define CEF_A_BUS_BIT     0
`define CEF_B_CHG_BIT     7
`define CEF_B_ICO_BIT     6
`define CEF_B_VBUS_BIT    4
`define CEF_B_TREG_BIT    2
`define CEF_B_BAT_BIT     1
`define CEF_B_DET_BIT     0
`define CEF_B_RSVD_MASK   8'hd7
`endif
